// ==== rtl/fjtap_pkg.sv ====
// fjtap_pkg: constants and types for the fifo test access port
// assumes: used by fjtap_top and fjtap_shifter
package fjtap_pkg;

    // --------------------------------------------------------------------
    // tap controller states, one-hot
    // --------------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAP_DR     = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPD_DR     = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAP_IR     = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPD_IR     = 16'h8000
    } fjtap_state_t;

    // --------------------------------------------------------------------
    // register layout
    // --------------------------------------------------------------------
    localparam int          IR_W         = 4;
    localparam int          ID_W         = 32;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;   // fixed 01 in low bits
    localparam logic [3:0]  IR_IDCODE    = 4'h2;
    localparam logic [3:0]  IR_BYPASS    = 4'hf;
    localparam logic [3:0]  IR_RESET_VAL = IR_IDCODE;
    // identification value: arbitrary, bit 0 must be one
    localparam logic [31:0] ID_VALUE     = 32'h0a5c_3001;

endpackage

// ==== rtl/fjtap_shift_if.sv ====
// fjtap_shift_if: carries decoded tck edge events and shift control
// assumes: driven by the tap core inside fjtap_top, read by fjtap_shifter, which drives serial_out, instr and sel_id
`timescale 1ns/100ps
`default_nettype none
interface fjtap_shift_if;
    logic       rise;       // tck rising edge seen this cycle
    logic       fall;       // tck falling edge seen this cycle
    logic       tdi;        // sampled serial input
    logic       capture_dr;
    logic       shift_dr;
    logic       capture_ir;
    logic       shift_ir;
    logic       upd_ir;
    logic       reset_tap;
    logic       sel_id;     // id register selected by current instruction
    logic       serial_out; // bit to present on the next falling edge
    logic [3:0] instr;

    modport core (output rise, fall, tdi, capture_dr, shift_dr, capture_ir, shift_ir,
                  upd_ir, reset_tap, input serial_out, instr, sel_id);
    modport shifter (input rise, fall, tdi, capture_dr, shift_dr, capture_ir, shift_ir,
                     upd_ir, reset_tap, output serial_out, instr, sel_id);
endinterface
`default_nettype wire

// ==== rtl/fjtap_shifter.sv ====
// fjtap_shifter: instruction, identification and bypass shift registers
// assumes: events arrive already synchronised to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module fjtap_shifter
    import fjtap_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        tap_rst_b_i,
    fjtap_shift_if.shifter   sif
);
    typedef struct packed {
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic [ID_W-1:0] id_sh;
        logic            byp;
    } fjtap_sh_t;

    fjtap_sh_t st;
    fjtap_sh_t next_st;

    // --------------------------------------------------------------------
    // shift and update
    // --------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (sif.reset_tap) begin
            next_st.ir = IR_RESET_VAL;
        end else if (sif.rise) begin
            if (sif.capture_ir) next_st.ir_sh = IR_CAPTURE;
            if (sif.shift_ir)   next_st.ir_sh = {sif.tdi, st.ir_sh[IR_W-1:1]};
            if (sif.upd_ir)     next_st.ir = st.ir_sh;
            if (sif.capture_dr) begin
                next_st.id_sh = ID_VALUE;
                next_st.byp   = 1'b0;
            end
            if (sif.shift_dr) begin
                next_st.id_sh = {sif.tdi, st.id_sh[ID_W-1:1]};
                next_st.byp   = sif.tdi;
            end
        end
    end

    // data register chosen by instruction; any code but idcode is bypass
    assign sif.sel_id     = (st.ir == IR_IDCODE);
    assign sif.instr      = st.ir;
    assign sif.serial_out = sif.shift_ir ? st.ir_sh[0] : (sif.sel_id ? st.id_sh[0] : st.byp);

    // tap reset line acts without a clock; core reset too
    always_ff @(posedge core_clk_i or negedge rst_b_i or negedge tap_rst_b_i) begin
        if (!rst_b_i || !tap_rst_b_i) begin
            st <= '{ir_sh: '0, ir: IR_RESET_VAL, id_sh: '0, byp: 1'b0};
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/fjtap_top.sv ====
// fjtap_top: boundary-scan test access port of a dual-clock fifo
// assumes: tck, tms, tdi, trst arrive from the tester asynchronously; all but trst are
// oversampled by core_clk_i (tck well below core_clk_i / 4)
//
// Operation
// - tms and tdi are taken on tck rising edges and tdo changes only on tck falling edges; trst and the core reset also clear tdo at once.
// - serial input bits shift on tck rising edges into the instruction, id or bypass register.
// - the selected register shifts out on tdo on tck falling edges.
// - tdo is not driven except in the shift-dr or shift-ir states.
// - tdi and tms read as high when left unconnected, through pull-ups.
// - the controller moves between states by the tms value taken on each tck rising edge.
// - asserting the test reset forces the controller to reset at once, without tck.
// - the controller is not reset at power-up; the tester resets it by trst or five tck cycles of tms high.
// - fifo data outputs stay undriven until the controller has been properly reset.
`timescale 1ns/100ps
`default_nettype none
module fjtap_top
    import fjtap_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        tck_i,
    input  wire logic        tms_i,
    input  wire logic        tms_pu_en_i,
    input  wire logic        tdi_i,
    input  wire logic        tdi_pu_en_i,
    input  wire logic        trst_b_i,
    input  wire logic        fifo_master_reset_in_i,
    output logic             tdo_o,
    output logic             tdo_oe_o,
    output logic             fifo_out_en_o,
    output logic [3:0]       instr_o
);
    import fjtap_pkg::*;

    typedef struct packed {
        logic [1:0]   tck_s;
        logic [1:0]   tms_s;
        logic [1:0]   tdi_s;
        logic         tck_d;
        fjtap_state_t tap;
        logic         reset_seen;
        logic         tdo;
        logic         tdo_oe;
        logic         fifo_en;
        logic [3:0]   instr;
    } fjtap_top_t;

    fjtap_top_t    st;
    fjtap_top_t    next_st;
    fjtap_shift_if sif ();
    logic          tms_pin;
    logic          tdi_pin;
    logic          rise;
    logic          fall;

    // --------------------------------------------------------------------
    // pins and edge detection
    // --------------------------------------------------------------------
    // pull-up reads open pins high
    assign tms_pin = tms_i | ~tms_pu_en_i;
    assign tdi_pin = tdi_i | ~tdi_pu_en_i;
    // edges looked for on the second stage only
    assign rise = st.tck_s[1] & ~st.tck_d;
    assign fall = ~st.tck_s[1] & st.tck_d;

    // --------------------------------------------------------------------
    // controller next state
    // --------------------------------------------------------------------
    function automatic fjtap_state_t tap_next(input fjtap_state_t s, input logic m);
        unique case (s)
            TAP_RESET:    tap_next = m ? TAP_RESET   : TAP_IDLE;
            TAP_IDLE:     tap_next = m ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR  : TAP_CAP_DR;
            TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR  : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR  : TAP_SHIFT_DR;
            TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_IR:   tap_next = m ? TAP_RESET   : TAP_CAP_IR;
            TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR  : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR  : TAP_SHIFT_IR;
            TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR  : TAP_IDLE;
            default:      tap_next = TAP_RESET;   // illegal code recovers via reset
        endcase
    endfunction

    // shifter events, all but reset_tap qualified inside the shifter by the rising edge
    assign sif.rise       = rise;
    assign sif.fall       = fall;
    assign sif.tdi        = st.tdi_s[1];
    assign sif.capture_dr = (st.tap == TAP_CAP_DR);
    assign sif.shift_dr   = (st.tap == TAP_SHIFT_DR);
    assign sif.capture_ir = (st.tap == TAP_CAP_IR);
    assign sif.shift_ir   = (st.tap == TAP_SHIFT_IR);
    assign sif.upd_ir     = (st.tap == TAP_UPD_IR);
    assign sif.reset_tap  = (st.tap == TAP_RESET);

    fjtap_shifter u_shifter (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .tap_rst_b_i (trst_b_i),
        .sif         (sif)
    );

    // --------------------------------------------------------------------
    // combinational update
    // --------------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.tck_s = {st.tck_s[0], tck_i};
        next_st.tms_s = {st.tms_s[0], tms_pin};
        next_st.tdi_s = {st.tdi_s[0], tdi_pin};
        next_st.tck_d = st.tck_s[1];
        next_st.instr = sif.instr;
        if (rise) begin
            next_st.tap = tap_next(st.tap, st.tms_s[1]);
        end
        // five tms-high edges reach reset state
        if (st.tap == TAP_RESET) begin
            next_st.reset_seen = 1'b1;
        end
        if (fall) begin
            next_st.tdo    = sif.serial_out;
            next_st.tdo_oe = sif.shift_dr | sif.shift_ir;
        end
        // fifo outputs held off until tap reset seen
        next_st.fifo_en = st.reset_seen;
    end

    // --------------------------------------------------------------------
    // state register
    // --------------------------------------------------------------------
    // trst acts asynchronously; core reset leaves tap unreset on purpose
    // trst may be the master reset tied in by the system
    always_ff @(posedge core_clk_i or negedge rst_b_i or negedge trst_b_i) begin
        if (!trst_b_i) begin
            st            <= '0;
            st.tap        <= TAP_RESET;
            st.reset_seen <= 1'b1;
            st.fifo_en    <= 1'b1;          // once enabled, only the core reset clears it
            st.instr      <= IR_RESET_VAL;
        end else if (!rst_b_i) begin
            st       <= '0;
            st.tap   <= TAP_IDLE;       // power-up state is not reset
            st.instr <= IR_RESET_VAL;
        end else begin
            st <= next_st;
        end
    end

    assign tdo_o         = st.tdo;
    assign tdo_oe_o      = st.tdo_oe;
    assign fifo_out_en_o = st.fifo_en;
    assign instr_o       = st.instr;
endmodule
`default_nettype wire

// ==== bench/fjtap_top_assertions.sv ====
// fjtap_top_assertions: port-level timing checks of the test access port
// assumes: bound into fjtap_top; tck stays far slower than core_clk_i
`timescale 1ns/100ps
`default_nettype none
module fjtap_top_assertions
    import fjtap_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic       tck_i,
    input wire logic       tms_i,
    input wire logic       tms_pu_en_i,
    input wire logic       trst_b_i,
    input wire logic       tdo_o,
    input wire logic       tdo_oe_o,
    input wire logic       fifo_out_en_o,
    input wire logic [3:0] instr_o
);
    // ----
    // edge ages, saturating so an idle tck raises nothing
    // ----
    logic       tck_q;
    logic       tms_hi;
    logic [2:0] since_fall;
    logic [2:0] since_rise;
    logic [2:0] trst_age;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tck_q      <= 1'b0;
            tms_hi     <= 1'b0;
            since_fall <= 3'h7;
            since_rise <= 3'h7;
            trst_age   <= 3'h7;
        end else begin
            tck_q      <= tck_i;
            tms_hi     <= (!tck_q && tck_i) ? (tms_i || !tms_pu_en_i) : tms_hi;
            since_fall <= (tck_q && !tck_i) ? 3'h0 : since_fall + 3'(since_fall != 3'h7);
            since_rise <= (!tck_q && tck_i) ? 3'h0 : since_rise + 3'(since_rise != 3'h7);
            trst_age   <= !trst_b_i ? 3'h0 : trst_age + 3'(trst_age != 3'h7);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // ----
    // properties
    // ----
    property p_tdo_fall; $changed(tdo_o) && trst_b_i && $past(trst_b_i) |-> since_fall inside {[3'h2:3'h6]}; endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a tck fall");
    property p_oe_fall; $changed(tdo_oe_o) && trst_b_i && $past(trst_b_i) |-> since_fall inside {[3'h2:3'h6]}; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off a tck fall");
    property p_trst_oe; !trst_b_i |-> ##[0:1] !tdo_oe_o; endproperty
    a_trst_oe: assert property (p_trst_oe) else $error("tdo driven in tap reset");
    property p_trst_en; $rose(trst_b_i) |-> ##[0:2] fifo_out_en_o; endproperty
    a_trst_en: assert property (p_trst_en) else $error("outputs not enabled after tap reset");
    property p_en_hold; fifo_out_en_o |=> fifo_out_en_o; endproperty
    a_en_hold: assert property (p_en_hold) else $error("output enable dropped");
    property p_en_cause; $rose(fifo_out_en_o) |-> !trst_b_i || trst_age < 3'h4 ||
        (tms_hi && since_rise inside {[3'h2:3'h6]});
    endproperty
    a_en_cause: assert property (p_en_cause) else $error("outputs enabled without tap reset");
    property p_instr_rst; !trst_b_i |=> instr_o == IR_RESET_VAL; endproperty
    a_instr_rst: assert property (p_instr_rst) else $error("instruction not reset");
    property p_instr_upd; $changed(instr_o) && trst_b_i && $past(trst_b_i) |-> !tdo_oe_o; endproperty
    a_instr_upd: assert property (p_instr_upd) else $error("instruction changed while shifting");
endmodule
bind fjtap_top fjtap_top_assertions u_chk (.core_clk_i, .rst_b_i, .tck_i, .tms_i, .tms_pu_en_i, .trst_b_i,
    .tdo_o, .tdo_oe_o, .fifo_out_en_o, .instr_o);
`default_nettype wire

// ==== bench/fjtap_tester.sv ====
// fjtap_tester: behavioural boundary-scan tester on the tap pins
// assumes: tck stands low between calls; tdi is released outside shifts
`timescale 1ns/100ps
`default_nettype none
module fjtap_tester (
    output logic       tck_o,
    output logic       tms_o,
    output logic       tdi_o,
    output logic       tdi_pu_en_o,
    output logic       trst_b_o,
    input  wire logic  tdo_i,
    input  wire logic  tdo_oe_i
);
    event       seen;
    logic [1:0] got;
    // tck rests at ground while no scan runs
    initial begin
        tck_o       = 1'b0;
        tms_o       = 1'b1;
        tdi_o       = 1'b0;
        tdi_pu_en_o = 1'b0;
        trst_b_o    = 1'b1;
    end
    // change at fall, sample before next fall
    task automatic step(input logic m, input logic d, input logic s);
        tms_o       = m;
        tdi_o       = s ? d : ~tdi_o;   // released pin must not look held
        tdi_pu_en_o = s;
        #16 tck_o = 1'b1;
        #16 got = {tdo_oe_i, tdo_i};
        if (s) ->seen;
        tck_o = 1'b0;
    endtask
    task automatic reset_tap();
        trst_b_o = 1'b0;
        #20 trst_b_o = 1'b1;
        #12;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_fjtap_top.sv ====
// tb_fjtap_top: self-checking bench for the fifo test access port
// assumes: fjtap_tester drives the tap pins; the checker is bound in
`timescale 1ns/100ps
`default_nettype none
module tb_fjtap_top;
    import fjtap_pkg::*;
    logic        clk, rst_b, tms_pu_en, tck, tms, tdi, tdi_pu_en, trst_b, tdo, tdo_oe, fifo_en;
    logic [3:0]  instr, code;
    logic [31:0] pat;
    logic [1:0]  exp_q[$];
    int          mismatches = 0;
    int          tests_run  = 0;
    int          cyc        = 0;
    // master reset tied to the test reset line
    fjtap_top u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .tck_i(tck), .tms_i(tms), .tms_pu_en_i(tms_pu_en),
        .tdi_i(tdi), .tdi_pu_en_i(tdi_pu_en), .trst_b_i(trst_b), .fifo_master_reset_in_i(~trst_b),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .fifo_out_en_o(fifo_en), .instr_o(instr));
    fjtap_tester u_tst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdi_pu_en_o(tdi_pu_en), .trst_b_o(trst_b),
        .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] obs, input logic [31:0] want);
        tests_run++;
        if (obs !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, obs);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // tms walks and lsb-first shifts, each shifted bit noted
    // ----
    task automatic walk(input logic [7:0] bits, input int n);
        for (int i = 0; i < n; i++) u_tst.step(bits[i], 1'b0, 1'b0);
    endtask
    task automatic shift(input logic [31:0] din, input logic [31:0] dout, input int n);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back({1'b1, dout[i]});
            u_tst.step(i == n - 1, din[i], 1'b1);
        end
        walk(8'h01, 2);   // update, then idle
    endtask
    always @(u_tst.seen) chk("tdo", u_tst.got, exp_q.pop_front());
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h29456e83));
        rst_b     = 1'b0;
        tms_pu_en = 1'b1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk) tms_pu_en <= 1'b0;
        #1.3 chk("fifo_en", fifo_en, 1'b0);
        // open tms reads high; core reset leaves the tap in idle, three highs reach reset
        walk(8'h00, 2);
        #24 chk("fifo_en", fifo_en, 1'b0);
        walk(8'h00, 3);
        #24 chk("fifo_en", fifo_en, 1'b1);
        @(posedge clk) tms_pu_en <= 1'b1;
        // bypass, id and one random code, each followed by a 32-bit data shift
        for (int k = 0; k < 3; k++) begin
            code = k == 0 ? IR_BYPASS : k == 1 ? IR_IDCODE : 4'($urandom());
            pat  = $urandom();
            walk(8'h06, 5);
            shift({28'h0, code}, {28'h0, IR_CAPTURE}, 4);
            #24 chk("instr", instr, code);
            walk(8'h02, 4);
            shift(pat, code == IR_IDCODE ? ID_VALUE : {pat[30:0], 1'b0}, 32);
        end
        // test reset in the middle of a data shift, tck standing still
        walk(8'h02, 4);
        #24 chk("tdo_oe", tdo_oe, 1'b1);
        u_tst.reset_tap();
        #8 chk("tdo_oe", tdo_oe, 1'b0);
        chk("instr", instr, IR_RESET_VAL);
        chk("fifo_en", fifo_en, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
